// ---- hdl/arc_adc_control.sv ----
// What this block does
// - Writing go one starts a conversion
// - Go during conversion restarts it
// - Go reads one until conversion finishes
// - Writing go zero does nothing
// - Reference code: off, one volt, two volts
// - Buffer bit one drives reference pin
// - Buffer bit zero frees reference pin
// - Single shot finishes after 5129 cycles
// - Continuous mode refreshes every 256 cycles
// - Codes zero to seven select inputs
// - Codes eight upward open all switches
// - Eleven bit result, upper byte readable
// - High read latches matching low bits
// - Low three bits in top positions
// - Overflow flag reports filter overflow
// - High byte holds latest conversion
// - Reserved low bits read zero
// - Continuous clears go, pulses each done
// - Idle 160 cycles powers down; 40 up
// - Clearing continuous stops conversions
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module arc_adc_control #(
    parameter logic [12:0] SINGLE_CYCLES = arc_pkg::SINGLE_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [arc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [10:0] core_result,
    input wire logic core_overflow,
    output logic [7:0] channel_switch,
    output logic [1:0] ref_level,
    output logic ref_buffer_enable,
    output logic ref_pin_oe,
    output logic core_power_enable,
    output logic conv_running,
    output logic conv_done
);
    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    arc_pkg::arc_ctl0_t ctl0;
    logic [7:0] ctl1;
    logic [7:0] res_high;
    logic [7:0] res_low;
    arc_pkg::arc_result_t shadow;

    wire setup = psel & ~penable;
    wire access = psel & penable & pready;
    wire wr = access & pwrite;
    wire rd_setup = setup & ~pwrite;
    wire [11:0] idx = paddr[arc_pkg::ADDR_W-1:2];
    wire hit_ctl0 = idx == arc_pkg::IDX_CONVERSION_CONTROL;
    wire hit_ctl1 = idx == arc_pkg::IDX_REFERENCE_HIGH_CONTROL;
    wire hit_high = idx == arc_pkg::IDX_RESULT_HIGH_BYTE;
    wire hit_low = idx == arc_pkg::IDX_RESULT_LOW_BITS;
    wire mapped = (hit_ctl0 | hit_ctl1 | hit_high | hit_low) & (paddr[1:0] == 2'b00);
    wire rd_high = rd_setup & hit_high & mapped;
    wire go_write = wr & hit_ctl0 & mapped & pwdata[arc_pkg::GO_BIT];
    wire ctl0_write = wr & hit_ctl0 & mapped;
    wire [7:0] rd_mux = hit_ctl0 ? ctl0 : hit_ctl1 ? ctl1 : hit_high ? res_high : hit_low ? res_low : 8'h00;

    // Read data is registered in the setup cycle, so every read answers with one wait-free access phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup & ~pready;
            if (setup) begin
                prdata <= {24'h00_0000, mapped ? rd_mux : 8'h00};
                pslverr <= ~mapped;
            end
        end
    end

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    arc_pkg::arc_state_t state;
    arc_pkg::arc_state_t next_state;
    logic [12:0] count;
    logic [12:0] next_count;
    logic [12:0] idle_count;
    logic first_conv;
    logic powered_down;

    wire [12:0] conv_last = first_conv ? SINGLE_CYCLES - 13'd1 : arc_pkg::CONTINUOUS_SELECT_CYCLES - 13'd1;
    // A fresh go write beats a completion in the same cycle, so the restart is never lost.
    wire done_eff = (state == arc_pkg::ARC_CONVERT) & (count == conv_last) & ~go_write;
    wire continuous_select_stop = (state == arc_pkg::ARC_CONVERT) & ~first_conv & ~ctl0.continuous_select;
    wire idle_expire = (state == arc_pkg::ARC_IDLE) & ~powered_down & (idle_count == arc_pkg::IDLE_CYCLES - 13'd1);
    wire next_powered_down = ((powered_down | idle_expire) & ~(state == arc_pkg::ARC_POWERUP & next_state ==
        arc_pkg::ARC_CONVERT)) & ~(go_write & ~powered_down);

    always_comb begin
        next_state = state;
        next_count = count + 13'd1;
        case (state)
            arc_pkg::ARC_IDLE: begin
                next_count = 13'd0;
                if (go_write) begin
                    next_state = powered_down ? arc_pkg::ARC_POWERUP : arc_pkg::ARC_CONVERT;
                end
            end
            arc_pkg::ARC_POWERUP: begin
                if (go_write) begin
                    next_count = 13'd0;
                end else if (count == arc_pkg::POWERUP_CYCLES - 13'd1) begin
                    next_state = arc_pkg::ARC_CONVERT;
                    next_count = 13'd0;
                end
            end
            arc_pkg::ARC_CONVERT: begin
                if (go_write) begin
                    next_count = 13'd0;
                end else if (continuous_select_stop) begin
                    next_state = arc_pkg::ARC_IDLE;
                end else if (done_eff) begin
                    next_count = 13'd0;
                    if (!ctl0.continuous_select) begin
                        next_state = arc_pkg::ARC_IDLE;
                    end
                end
            end
            default: begin
                next_state = arc_pkg::ARC_IDLE;
                next_count = 13'd0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= arc_pkg::ARC_IDLE;
            count <= 13'd0;
            first_conv <= 1'b0;
            powered_down <= 1'b1;
            idle_count <= 13'd0;
        end else begin
            state <= next_state;
            count <= next_count;
            first_conv <= go_write | (first_conv & ~done_eff);
            powered_down <= next_powered_down;
            idle_count <= (state == arc_pkg::ARC_IDLE && !go_write) ? idle_count + 13'd1 : 13'd0;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl0 <= arc_pkg::CONVERSION_CONTROL_RESET;
            ctl1 <= arc_pkg::REFERENCE_HIGH_CONTROL_RESET;
        end else begin
            if (ctl0_write) begin
                ctl0[6:0] <= pwdata[6:0];
            end
            if (go_write) begin
                ctl0.conversion_go <= 1'b1;
            end else if (done_eff & first_conv) begin
                ctl0.conversion_go <= 1'b0;
            end
            if (wr & hit_ctl1 & mapped) begin
                ctl1 <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Result registers
    // ------------------------------------------------------------
    // Result bits clear at reset only so the checks never meet unknown values.
    // Software must still treat them as undefined until the first conversion completes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_high <= 8'h00;
            res_low <= 8'h00;
            shadow <= 12'h000;
        end else begin
        if (done_eff) begin
            res_high <= core_result[10:3];
            shadow <= {core_result, core_overflow};
        end
        if (rd_high) begin
            // Both the high byte and the low latch use values from before any same-cycle update.
            res_low <= {shadow.result_lower_bits, 4'h0, shadow.filter_overflow_flag};
        end
        end
    end

    // ------------------------------------------------------------
    // Analog side outputs
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_switch
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    channel_switch[i] <= 1'b0;
                end else begin
                    channel_switch[i] <= ctl0.input_channel_select == 4'(i);
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_level <= 2'b10;
            ref_buffer_enable <= 1'b0;
            ref_pin_oe <= 1'b0;
            core_power_enable <= 1'b0;
            conv_running <= 1'b0;
            conv_done <= 1'b0;
        end else begin
            ref_level <= {ctl1[arc_pkg::REF_HIGH_BIT], ctl0.ref_level_low_bit};
            ref_buffer_enable <= ctl0.ref_pin_buffer_enable;
            ref_pin_oe <= ctl0.ref_pin_buffer_enable;
            // The converter must be supplied while it powers up, or the warm-up time is wasted.
            core_power_enable <= ~next_powered_down | (next_state == arc_pkg::ARC_POWERUP);
            conv_running <= next_state == arc_pkg::ARC_CONVERT;
            conv_done <= done_eff;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    go_start_a: assert property (@(posedge pclk) disable iff (!presetn)
        go_write |=> ctl0.conversion_go && state != arc_pkg::ARC_IDLE)
        else $error("Go write did not start a conversion.");
    go_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
        go_write && state == arc_pkg::ARC_CONVERT |=> count == 13'd0 && first_conv)
        else $error("Go write during conversion did not restart it.");
    go_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        done_eff && first_conv |=> !ctl0.conversion_go ##1 conv_done == 1'b0)
        else $error("Go bit not cleared at completion.");
    zero_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctl0_write && !pwdata[7] && !done_eff |=> ctl0.conversion_go == $past(ctl0.conversion_go))
        else $error("Writing zero to go changed it.");
    single_len_a: assert property (@(posedge pclk) disable iff (!presetn)
        done_eff && first_conv |-> count == SINGLE_CYCLES - 13'd1 && $past(state) == arc_pkg::ARC_CONVERT)
        else $error("Single conversion length wrong.");
    continuous_select_period_a: assert property (@(posedge pclk) disable iff (!presetn)
        done_eff && ctl0.continuous_select |=> !done_eff [*8])
        else $error("Continuous completions too close.");
    switch_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctl0.input_channel_select[3] |=> channel_switch == 8'h00)
        else $error("Reserved channel code closed a switch.");
    low_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !rd_high |=> $stable(res_low))
        else $error("Low result bits changed without a high read.");
    power_down_a: assert property (@(posedge pclk) disable iff (!presetn)
        idle_expire && !go_write |=> powered_down && !core_power_enable)
        else $error("Converter did not power down after idle time.");
    ref_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        ref_level == {$past(ctl1[arc_pkg::REF_HIGH_BIT]), $past(ctl0.ref_level_low_bit)})
        else $error("Reference level does not follow its select bits.");
    buffer_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
        ref_pin_oe == ref_buffer_enable && ref_pin_oe == $past(ctl0.ref_pin_buffer_enable))
        else $error("Reference pin buffer does not follow its enable bit.");
    go_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctl0.conversion_go && !(done_eff && first_conv) |=> ctl0.conversion_go)
        else $error("Go bit dropped before the conversion finished.");
    continuous_select_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
        continuous_select_stop && !go_write |=> state == arc_pkg::ARC_IDLE && !conv_running)
        else $error("Clearing continuous mode did not stop conversions.");
    done_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        done_eff |=> conv_done)
        else $error("Completion did not raise the done pulse.");
endmodule
`default_nettype wire

// ---- include/arc_pkg.sv ----
`default_nettype none
package arc_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    // Printed offsets are register indices; the byte address is four times the index.
    localparam int ADDR_W = 14;
    localparam logic [11:0] IDX_CONVERSION_CONTROL = 12'h0f70;
    localparam logic [11:0] IDX_REFERENCE_HIGH_CONTROL = 12'h0f71;
    localparam logic [11:0] IDX_RESULT_HIGH_BYTE = 12'h0f72;
    localparam logic [11:0] IDX_RESULT_LOW_BITS = 12'h0f73;
    localparam logic [7:0] CONVERSION_CONTROL_RESET = 8'h00;
    localparam logic [7:0] REFERENCE_HIGH_CONTROL_RESET = 8'h80;
    localparam int GO_BIT = 7;
    localparam int REF_HIGH_BIT = 7;
    localparam int LOW_DATA_POS = 5;
    localparam int OVF_POS = 0;

    // ------------------------------------------------------------
    // Timing in system clock cycles
    // ------------------------------------------------------------
    localparam logic [12:0] SINGLE_CYCLES = 13'h1409;
    localparam logic [12:0] CONTINUOUS_SELECT_CYCLES = 13'h0100;
    localparam logic [12:0] IDLE_CYCLES = 13'h00a0;
    localparam logic [12:0] POWERUP_CYCLES = 13'h0028;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic conversion_go;
        logic ref_level_low_bit;
        logic ref_pin_buffer_enable;
        logic continuous_select;
        logic [3:0] input_channel_select;
    } arc_ctl0_t;

    typedef struct packed {
        logic [7:0] result_upper_bits;
        logic [2:0] result_lower_bits;
        logic filter_overflow_flag;
    } arc_result_t;

    typedef enum logic [1:0] {
        ARC_IDLE = 2'b00,
        ARC_POWERUP = 2'b01,
        ARC_CONVERT = 2'b11
    } arc_state_t;
endpackage
`default_nettype wire

// ---- verif/adc_register_control_test.sv ----
`timescale 1ns/1ns
`default_nettype none
module adc_register_control_test;
    localparam int SP = 20;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ovf;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [10:0] core_result, smp;
    logic core_overflow, ref_buffer_enable, ref_pin_oe, core_power_enable, conv_running, conv_done;
    logic [7:0] channel_switch;
    logic [1:0] ref_level;
    int mismatches = 0;
    int compares = 0;
    int n;
    arc_adc_control #(.SINGLE_CYCLES(13'h0014)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .core_result(core_result), .core_overflow(core_overflow),
        .channel_switch(channel_switch), .ref_level(ref_level), .ref_buffer_enable(ref_buffer_enable),
        .ref_pin_oe(ref_pin_oe), .core_power_enable(core_power_enable), .conv_running(conv_running),
        .conv_done(conv_done));
    arc_core_model core (.pclk(pclk), .conv_running(conv_running), .sample(smp), .ovf(ovf),
        .core_result(core_result), .core_overflow(core_overflow));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; the request holds until pready is seen at a rising edge.
    task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            mismatches++;
            $display("MISMATCH %0t no pready", $time);
        end
        rdat = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wait_for(input logic run, input int lim, output int c);
        c = 0;
        do begin
            @(posedge pclk);
            c++;
        end while (c < lim && (run ? conv_running : conv_done) !== 1'b1);
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        apb(0, arc_pkg::IDX_CONVERSION_CONTROL, 8'h00);
        chk(rdat, 32'h0000_0000);
        apb(0, arc_pkg::IDX_REFERENCE_HIGH_CONTROL, 8'h00);
        chk(rdat, 32'h0000_0080);
        chk(ref_level, 2'b10);
        chk(ref_pin_oe, 1'b0);
        apb(0, 12'h0f74, 8'h00);
        chk(pslverr, 1'b1);
    endtask
    task automatic t_ref();
        for (int i = 0; i < 3; i++) begin
            apb(1, arc_pkg::IDX_REFERENCE_HIGH_CONTROL, {i[1], 7'h00});
            apb(1, arc_pkg::IDX_CONVERSION_CONTROL, {1'b0, i[0], 6'h20});
            @(posedge pclk);
            chk(ref_level, i[1:0]);
            chk({ref_pin_oe, ref_buffer_enable}, 2'b11);
        end
    endtask
    task automatic t_chan();
        for (int c = 0; c < 16; c++) begin
            apb(1, arc_pkg::IDX_CONVERSION_CONTROL, {4'h0, c[3:0]});
            @(posedge pclk);
            chk(channel_switch, c < 8 ? 8'h01 << c : 8'h00);
        end
        chk(ref_pin_oe, 1'b0);
    endtask
    task automatic t_single();
        smp <= 11'h5a3;
        ovf <= 1'b1;
        apb(1, arc_pkg::IDX_CONVERSION_CONTROL, 8'h83);
        apb(0, arc_pkg::IDX_CONVERSION_CONTROL, 8'h00);
        chk(rdat, 32'h0000_0083);
        wait_for(1, 100, n);
        wait_for(0, 100, n);
        chk(n, SP);
        apb(0, arc_pkg::IDX_CONVERSION_CONTROL, 8'h00);
        chk(rdat, 32'h0000_0003);
        apb(0, arc_pkg::IDX_RESULT_HIGH_BYTE, 8'h00);
        chk(rdat, {24'h00_0000, smp[10:3]});
        apb(0, arc_pkg::IDX_RESULT_LOW_BITS, 8'h00);
        chk(rdat, {24'h00_0000, smp[2:0], 4'h0, ovf});
    endtask
    task automatic t_restart();
        apb(1, arc_pkg::IDX_CONVERSION_CONTROL, 8'h83);
        wait_for(1, 100, n);
        apb(1, arc_pkg::IDX_CONVERSION_CONTROL, 8'h03);
        apb(0, arc_pkg::IDX_CONVERSION_CONTROL, 8'h00);
        chk(rdat, 32'h0000_0083);
        apb(1, arc_pkg::IDX_CONVERSION_CONTROL, 8'h83);
        wait_for(0, 100, n);
        chk(n >= SP, 1'b1);
    endtask
    task automatic t_continuous_select();
        apb(1, arc_pkg::IDX_CONVERSION_CONTROL, 8'h93);
        wait_for(0, 200, n);
        smp <= 11'h123;
        ovf <= 1'b0;
        wait_for(0, 600, n);
        chk(n, 256);
        apb(0, arc_pkg::IDX_CONVERSION_CONTROL, 8'h00);
        chk(rdat, 32'h0000_0013);
        apb(0, arc_pkg::IDX_RESULT_HIGH_BYTE, 8'h00);
        chk(rdat, 32'h0000_0024);
        smp <= 11'h7ff;
        wait_for(0, 300, n);
        apb(0, arc_pkg::IDX_RESULT_LOW_BITS, 8'h00);
        chk(rdat, 32'h0000_0060);
        apb(1, arc_pkg::IDX_CONVERSION_CONTROL, 8'h03);
        wait_for(0, 300, n);
        chk(n, 300);
    endtask
    task automatic t_power();
        repeat (170) @(posedge pclk);
        chk(core_power_enable, 1'b0);
        apb(1, arc_pkg::IDX_CONVERSION_CONTROL, 8'h82);
        wait_for(1, 100, n);
        chk(n >= 40 && n <= 45, 1'b1);
        chk(core_power_enable, 1'b1);
        wait_for(0, 100, n);
        chk(n, SP);
    endtask
    // ----------------------------------------
    // Clock, reset, sequence, watchdog
    // ----------------------------------------
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, ovf} = 5'h00;
        paddr = 14'h0000;
        pwdata = 32'h0000_0000;
        smp = 11'h000;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_ref();
        t_chan();
        t_single();
        t_restart();
        t_continuous_select();
        t_power();
        close_out();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        close_out();
    end
endmodule
`default_nettype wire

// ---- verif/arc_core_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Sampling core stand-in
// ----------------------------------------
// Outside a conversion the sample lines carry a pattern that changes each cycle.
// A design that latches at the wrong moment then reads the inverted sample on every other cycle, not a steady match.
module arc_core_model (
    input wire logic pclk,
    input wire logic conv_running,
    input wire logic [10:0] sample,
    input wire logic ovf,
    output logic [10:0] core_result,
    output logic core_overflow
);
    logic flip = 1'b0;
    always @(posedge pclk) begin
        flip <= ~flip;
    end
    assign core_result = conv_running ? sample : ({11{flip}} ^ ~sample);
    assign core_overflow = conv_running ? ovf : flip;
endmodule
`default_nettype wire
